// ---- hw/adiu_interrupt_unit.v ----
// Notes on behaviour
// - All interrupt enables cleared by reset
// - Undervoltage sets flag, interrupt if enabled
// - Undervoltage switches off all high-side drives
// - Overvoltage sets flag, switches off high sides
// - STOP mode blocks voltage and temperature detection
// - Overtemperature sets flag, interrupt if enabled
// - Bus falling edge sets flag, wakes STOP
// - RUN: enabled Hall input change sets flag
// - STOP: Hall flag needs cyclic check, wakes
// - Any overcurrent source sets overcurrent flag
// - Overcurrent flag cleared via system status
// - Hall and bus flags clear on one
// - Condition flags ignore clear while condition persists
// - Four wake events wake controller and regulator
// - Flag register bits 6..1, others zero
// - Mask register bits 6..1, others zero
// - Open-drain interrupt output toward controller
`include "adiu_regs.vh"
`default_nettype none
module adiu_interrupt_unit #(
  parameter HALL_INPUTS = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register access from the serial port decoder
  input wire [4:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  // Overcurrent clear strobe from the system status register
  input wire overcurrentClear,
  // Operating mode and watchdog status
  input wire stopMode,
  input wire watchdogCyclicCheck,
  input wire watchdogWake,
  input wire lowSupplyReset,
  // Analog detectors (asynchronous)
  input wire undervoltageDet,
  input wire overvoltageDet,
  input wire overtempDet,
  input wire busLine,
  input wire [HALL_INPUTS-1:0] hallIn,
  input wire [HALL_INPUTS-1:0] hallEnable,
  input wire bridgeOvercurrent,
  input wire highSideOvercurrent,
  input wire sensorSupplyOvercurrent,
  // Outputs
  output reg highSideOff,
  output reg wakeController,
  output reg wakeRegulator,
  output reg irqOut,
  output reg irqOe
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  // Slot of each input in the synchroniser vector
  localparam SI_OC = 0;
  localparam SI_BUS = 1;
  localparam SI_TEMP = 2;
  localparam SI_OV = 3;
  localparam SI_UV = 4;
  localparam SI_LSR = 5;
  localparam SI_WDW = 6;
  localparam SI_CC = 7;
  localparam SI_STOP = 8;
  localparam SI_HALL = 9;
  localparam SW = SI_HALL + HALL_INPUTS;
  wire [SW-1:0] syncIn;
  wire uvS;
  wire ovS;
  wire otS;
  wire busS;
  wire ocS;
  wire lsrS;
  wire wdwS;
  wire stopS;
  wire ccS;
  wire [HALL_INPUTS-1:0] hallS;

  // Bus line travels inverted: a cleared synchroniser then reads as an idle
  // high line, so leaving reset cannot look like a falling edge
  adiu_sync #(.WIDTH(SW)) inSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn({hallIn, stopMode, watchdogCyclicCheck, watchdogWake, lowSupplyReset,
      undervoltageDet, overvoltageDet, overtempDet, ~busLine,
      bridgeOvercurrent | highSideOvercurrent | sensorSupplyOvercurrent}),
    .syncOut(syncIn)
  );

  assign ocS = syncIn[SI_OC];
  // Bus level turned back to its true sense
  assign busS = !syncIn[SI_BUS];
  assign otS = syncIn[SI_TEMP];
  assign ovS = syncIn[SI_OV];
  assign uvS = syncIn[SI_UV];
  assign lsrS = syncIn[SI_LSR];
  assign wdwS = syncIn[SI_WDW];
  assign ccS = syncIn[SI_CC];
  assign stopS = syncIn[SI_STOP];
  assign hallS = syncIn[SW-1:SI_HALL];

  // ----------------------------------------
  // Registers and history
  // ----------------------------------------
  reg [7:0] mask_reg;
  reg [7:0] mask_next;
  reg [7:0] flags_reg;
  reg [7:0] flags_next;
  reg busPrev_reg;
  reg [HALL_INPUTS-1:0] hallPrev_reg;
  reg [7:0] setVec;
  reg [7:0] clrVec;
  wire wrMask;
  wire wrFlags;
  wire uvCond;
  wire ovCond;
  wire otCond;
  wire busEdge;
  wire hallRun;
  wire hallStop;
  wire anyIrq;
  wire wakeEvent;

  // Mask one bit position of a byte
  function [7:0] bitOf;
    input integer pos;
    begin
      bitOf = 8'h01 << pos;
    end
  endfunction

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  assign wrMask = regWrite && (regAddr == `ADIU_ADDR_MASK);
  assign wrFlags = regWrite && (regAddr == `ADIU_ADDR_FLAGS);

  assign uvCond = uvS && !stopS;
  assign ovCond = ovS && !stopS;
  assign otCond = otS && !stopS;

  assign busEdge = busPrev_reg && !busS;

  assign hallRun = !stopS && (|((hallS ^ hallPrev_reg) & hallEnable));
  // Level test, since the cyclic check powers the sensors only briefly
  // Stop-mode Hall with cyclic check
  assign hallStop = stopS && ccS && (|(hallS & hallEnable));

  // ----------------------------------------
  // Flag set and clear terms
  // ----------------------------------------
  always @*
  begin
    setVec = 8'h00;
    clrVec = 8'h00;
    if (uvCond)
      setVec = setVec | bitOf(`ADIU_BIT_UV);
    if (ovCond)
      setVec = setVec | bitOf(`ADIU_BIT_OV);
    if (otCond)
      setVec = setVec | bitOf(`ADIU_BIT_TEMP);
    if (busEdge)
      setVec = setVec | bitOf(`ADIU_BIT_BUS);
    if (hallRun || hallStop)
      setVec = setVec | bitOf(`ADIU_BIT_HALL);
    if (ocS)
      setVec = setVec | bitOf(`ADIU_BIT_OC);
    if (wrFlags)
      clrVec = regWdata & (bitOf(`ADIU_BIT_HALL) | bitOf(`ADIU_BIT_BUS) |
        bitOf(`ADIU_BIT_TEMP) | bitOf(`ADIU_BIT_UV) | bitOf(`ADIU_BIT_OV));
    // Overcurrent cleared from status side only
    if (overcurrentClear)
      clrVec = clrVec | bitOf(`ADIU_BIT_OC);
  end

  // Set wins over clear; a live condition keeps its flag set
  always @*
  begin
    flags_next = ((flags_reg & ~clrVec) | setVec) & `ADIU_IMPL_BITS;
  end

  always @*
  begin
    mask_next = mask_reg;
    if (wrMask)
      mask_next = regWdata & `ADIU_IMPL_BITS;
  end

  // ----------------------------------------
  // Interrupt and wake decisions
  // ----------------------------------------
  // From next values, so the line moves in the same cycle as the flag
  assign anyIrq = |(flags_next & mask_next);
  // Watchdog and low-supply wakes have no mask bit of their own
  // Unmasked wake events
  assign wakeEvent = (busEdge && mask_reg[`ADIU_BIT_BUS]) ||
    (hallStop && mask_reg[`ADIU_BIT_HALL]) || wdwS || lsrS;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Enables and flags cleared
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mask_reg <= `ADIU_RESET_VAL;
      flags_reg <= `ADIU_RESET_VAL;
    end
    else
    begin
      mask_reg <= mask_next;
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------
  // Input history for edge detection
  // ----------------------------------------
  // History starts at the idle levels the synchroniser shows after reset
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      busPrev_reg <= 1'b1;
      hallPrev_reg <= {HALL_INPUTS{1'b0}};
    end
    else
    begin
      busPrev_reg <= busS;
      hallPrev_reg <= hallS;
    end
  end

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  // Read mux, unused bits zero
  // Shows state before a same-cycle write, as the serial frame expects
  always @(posedge ref_clk)
  begin
    if (rst)
      regRdata <= `ADIU_RESET_VAL;
    else
    begin
      case (regAddr)
        `ADIU_ADDR_MASK: regRdata <= mask_reg;
        `ADIU_ADDR_FLAGS: regRdata <= flags_reg;
        default: regRdata <= `ADIU_RESET_VAL;
      endcase
    end
  end

  // ----------------------------------------
  // Power stage and wake outputs
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      highSideOff <= 1'b0;
      wakeController <= 1'b0;
      wakeRegulator <= 1'b0;
    end
    else
    begin
      // High sides off during supply fault
      highSideOff <= uvCond || ovCond;
      // Wake both controller and regulator, only in STOP
      wakeController <= stopS && wakeEvent;
      wakeRegulator <= stopS && wakeEvent;
    end
  end

  // ----------------------------------------
  // Interrupt line
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end
    else
    begin
      irqOut <= 1'b0;
      irqOe <= anyIrq;
    end
  end
endmodule
`default_nettype wire

// ---- hw/adiu_regs.vh ----
`ifndef ADIU_REGS_VH
`define ADIU_REGS_VH
// ----------------------------------------
// Register addresses (5-bit register space)
// ----------------------------------------
`define ADIU_ADDR_MASK 5'h04
`define ADIU_ADDR_FLAGS 5'h05
`define ADIU_RESET_VAL 8'h00
// ----------------------------------------
// Bit positions, shared by flags and mask
// ----------------------------------------
`define ADIU_BIT_HALL 6
`define ADIU_BIT_BUS 5
`define ADIU_BIT_TEMP 4
`define ADIU_BIT_UV 3
`define ADIU_BIT_OV 2
`define ADIU_BIT_OC 1
// Implemented bits 6..1, bits 7 and 0 read zero
`define ADIU_IMPL_BITS 8'h7E
`endif

// ---- hw/adiu_sync.v ----
`default_nettype none
// ----------------------------------------
// Two-stage synchroniser, vector wide
// ----------------------------------------
module adiu_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Data
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // First stage is read by the second stage only
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ---- test/adiu_mcu_model.sv ----
`default_nettype none
// ------------------------------
// Controller side of the line
// ------------------------------
module adiu_mcu_model (
  // Die side
  input wire logic irqOut,
  input wire logic irqOe,
  // Controller pin
  output logic irqLineN
);
  timeunit 1ns;
  timeprecision 1ps;
  assign irqLineN = irqOe ? irqOut : 1'h1;
endmodule
`default_nettype wire

// ---- test/adiu_irq_asserts.sv ----
`default_nettype none
// ------------------------------
// Port checks
// ------------------------------
module adiu_irq_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire logic [7:0] regRdata,
  input wire logic stopMode,
  input wire logic watchdogWake,
  input wire logic undervoltageDet,
  input wire logic overvoltageDet,
  input wire logic highSideOff,
  input wire logic wakeController,
  input wire logic wakeRegulator,
  input wire logic irqOut,
  input wire logic irqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Four samples cover two sync stages and the output flop
  sequence faultHeld;
    ((undervoltageDet || overvoltageDet) && !stopMode) [*4];
  endsequence
  rst_quiet_a: assert property (disable iff (1'h0)
    rst |=> !irqOe && !highSideOff && !wakeController) else $error("output after reset");
  hs_set_a: assert property (faultHeld |-> highSideOff)
    else $error("high side not off");
  hs_clear_a: assert property (
    ((!undervoltageDet && !overvoltageDet) || stopMode) [*4] |-> !highSideOff)
    else $error("high side off idle");
  wake_run_a: assert property ((!stopMode) [*4] |-> !wakeController)
    else $error("wake in run");
  wake_pair_a: assert property (wakeController == wakeRegulator)
    else $error("wake split");
  wd_wake_a: assert property ((stopMode && watchdogWake) [*4] |-> wakeController)
    else $error("no wake");
  resv_bits_a: assert property (!regRdata[7] && !regRdata[0])
    else $error("reserved bit set");
  out_zero_a: assert property (!irqOut)
    else $error("irq data high");
endmodule
bind adiu_interrupt_unit adiu_irq_asserts i_chk (.ref_clk, .rst, .regRdata, .stopMode,
  .watchdogWake, .undervoltageDet, .overvoltageDet, .highSideOff, .wakeController,
  .wakeRegulator, .irqOut, .irqOe);
`default_nettype wire

// ---- test/test_analog_die_interrupt_unit.sv ----
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
// ------------------------------
// Bench top
// ------------------------------
module test_analog_die_interrupt_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, regWrite = 1'h0, overcurrentClear = 1'h0;
  logic stopMode = 1'h0, watchdogWake = 1'h0, busLine = 1'h1;
  logic watchdogCyclicCheck = 1'h0, lowSupplyReset = 1'h0;
  logic [2:0] hallEnable = 3'h7;
  logic undervoltageDet = 1'h0, overvoltageDet = 1'h0, overtempDet = 1'h0;
  logic bridgeOvercurrent = 1'h0, highSideOvercurrent = 1'h0, sensorSupplyOvercurrent = 1'h0;
  logic [2:0] hallIn = 3'h0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic highSideOff, wakeController, wakeRegulator, irqOut, irqOe, irqLineN;
  // Flag expected per source: uv, ov, temp, three overcurrents, bus, hall
  logic [7:0] bitTab [8] = '{8'h08, 8'h04, 8'h10, 8'h02, 8'h02, 8'h02, 8'h20, 8'h40};
  int num_errors = 0;
  int n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  adiu_interrupt_unit i_dut (.ref_clk, .rst, .regAddr, .regWrite, .regWdata, .regRdata,
    .overcurrentClear, .stopMode, .watchdogCyclicCheck, .watchdogWake,
    .lowSupplyReset, .undervoltageDet, .overvoltageDet, .overtempDet, .busLine,
    .hallIn, .hallEnable, .bridgeOvercurrent, .highSideOvercurrent,
    .sensorSupplyOvercurrent, .highSideOff, .wakeController, .wakeRegulator, .irqOut, .irqOe);
  adiu_mcu_model i_mcu (.irqOut, .irqOe, .irqLineN);
  // Register access, strobe held for exactly one edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    regAddr = a;
    regWdata = d;
    regWrite = 1'h1;
    @(posedge ref_clk) #1;
    regWrite = 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk) #1;
    regAddr = a;
    @(posedge ref_clk) #1;
    `CHK("regRdata", e, regRdata)
  endtask
  task automatic src(input int k, input logic v);
    case (k)
      0: undervoltageDet = v;
      1: overvoltageDet = v;
      2: overtempDet = v;
      3: bridgeOvercurrent = v;
      4: highSideOvercurrent = v;
      5: sensorSupplyOvercurrent = v;
      6: busLine = !v;
      default: hallIn[0] = v;
    endcase
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Tests need about 5 us; ten times that means a hang
  initial
  begin
    #50us;
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'h0;
    rd(5'h04, 8'h00);
    rd(5'h05, 8'h00);
    rd(5'h1F, 8'h00);
    `CHK("irqLineN", 1'h1, irqLineN)
    wr(5'h04, 8'hFF);
    rd(5'h04, 8'h7E);
    for (int k = 0; k < 8; k++)
    begin
      src(k, 1'h1);
      repeat (5) @(posedge ref_clk);
      rd(5'h05, bitTab[k]);
      `CHK("irqLineN", 1'h0, irqLineN)
      `CHK("highSideOff", k < 2, highSideOff)
      wr(5'h05, 8'h7E);
      rd(5'h05, k < 6 ? bitTab[k] : 8'h00);
      src(k, 1'h0);
      repeat (5) @(posedge ref_clk);
      wr(5'h05, 8'h7E);
      @(posedge ref_clk) #1 overcurrentClear = 1'h1;
      @(posedge ref_clk) #1 overcurrentClear = 1'h0;
      rd(5'h05, 8'h00);
      `CHK("irqLineN", 1'h1, irqLineN)
    end
    wr(5'h04, 8'h00);
    src(0, 1'h1);
    repeat (5) @(posedge ref_clk);
    `CHK("irqLineN", 1'h1, irqLineN)
    src(0, 1'h0);
    repeat (5) @(posedge ref_clk);
    wr(5'h05, 8'h7E);
    stopMode = 1'h1;
    overvoltageDet = 1'h1;
    watchdogWake = 1'h1;
    repeat (5) @(posedge ref_clk);
    rd(5'h05, 8'h00);
    `CHK("highSideOff", 1'h0, highSideOff)
    `CHK("wakeController", 1'h1, wakeController)
    watchdogWake = 1'h0;
    wr(5'h04, 8'h60);
    repeat (5) @(posedge ref_clk);
    `CHK("wakeController", 1'h0, wakeController)
    hallEnable = 3'h5;
    watchdogCyclicCheck = 1'h1;
    hallIn[1] = 1'h1;
    repeat (5) @(posedge ref_clk);
    rd(5'h05, 8'h00);
    hallEnable = 3'h7;
    repeat (5) @(posedge ref_clk);
    rd(5'h05, 8'h40);
    `CHK("wakeRegulator", 1'h1, wakeRegulator)
    `CHK("irqLineN", 1'h0, irqLineN)
    hallIn[1] = 1'h0;
    watchdogCyclicCheck = 1'h0;
    repeat (5) @(posedge ref_clk);
    wr(5'h05, 8'h7E);
    busLine = 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("wakeController", 1'h1, wakeController)
    @(posedge ref_clk) #1;
    `CHK("wakeController", 1'h0, wakeController)
    rd(5'h05, 8'h20);
    busLine = 1'h1;
    lowSupplyReset = 1'h1;
    repeat (5) @(posedge ref_clk);
    `CHK("wakeController", 1'h1, wakeController)
    lowSupplyReset = 1'h0;
    summarize();
  end
endmodule
`default_nettype wire
